// ---- hcoc_cfg.svh ----
// Offsets, field positions, reset values and counts of the host clock block
`ifndef HCOC_CFG_SVH
`define HCOC_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
`define HCOC_ADDR_ANA1        8'h00
`define HCOC_ADDR_ANA0        8'h01
`define HCOC_ADDR_PIN3        8'h02
`define HCOC_ADDR_PIN2        8'h03
`define HCOC_ADDR_CLKCFG      8'h06
`define HCOC_ADDR_STATUS      8'h07
`define HCOC_ADDR_EVENTS      8'h08

////////////////////////////////////////////////////////////////////////////////
`define HCOC_RST_ANA1         8'h0C
`define HCOC_RST_ANA0         8'hC0
`define HCOC_RST_PIN          8'hA2
`define HCOC_RST_CLKCFG       8'h00

////////////////////////////////////////////////////////////////////////////////
`define HCOC_CLK_EN_BIT       7
`define HCOC_TAIL_HI          6
`define HCOC_TAIL_LO          5
`define HCOC_XO_HI            4
`define HCOC_XO_LO            1
`define HCOC_RC_BIT           0
`define HCOC_REF26_BIT        6
`define HCOC_AES_BIT          5
`define HCOC_EXTREF_BIT       4
`define HCOC_BROWN_BIT        2
`define HCOC_BATT_BIT         1
`define HCOC_TEMP_BIT         0

////////////////////////////////////////////////////////////////////////////////
`define HCOC_TAIL_W           10
`define HCOC_TAIL_0           10'h000
`define HCOC_TAIL_1           10'h040
`define HCOC_TAIL_2           10'h100
`define HCOC_TAIL_3           10'h200
`define HCOC_TAIL_MAX_CYC     98304
`define HCOC_WD_W             17
`define HCOC_PER_W            9
`define HCOC_PER_RC1          9'h002
`define HCOC_PER_RC128        9'h100

`endif

// ---- hcoc_divider.sv ----
// Edge counting divider that changes ratio and stops only at period ends
`timescale 1ns/1ns
`include "hcoc_cfg.svh"
module hcoc_divider #(
	parameter int PW = `HCOC_PER_W
)(
	// System
	input  wire logic          clk_sys,
	input  wire logic          rstn,
	// Source and control
	input  wire logic          src_level,
	input  wire logic [PW-1:0] period_in,
	input  wire logic          run,
	// Divided clock
	output logic               clk_out,
	output logic               idle,
	output logic               wrap
);

	logic          prev;
	logic          run_q;
	logic [PW-1:0] count;
	logic [PW-1:0] per;
	logic          edge_seen;
	logic [PW-1:0] half;

	// Period counted in source half periods, high phase rounded up
	assign edge_seen = src_level != prev;
	assign half      = (per + PW'(1)) >> 1;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			prev    <= 1'b0;
			run_q   <= 1'b0;
			count   <= '0;
			per     <= `HCOC_PER_RC1;
			clk_out <= 1'b0;
			idle    <= 1'b1;
			wrap    <= 1'b0;
		end else begin
			prev <= src_level;
			run_q <= run;
			wrap <= 1'b0;
			if (idle) begin
				// First run cycle after a source swap compares against the old source
				if (run && run_q && edge_seen) begin
					count   <= '0;
					per     <= period_in;
					clk_out <= 1'b1;
					idle    <= 1'b0;
				end
			end else if (edge_seen) begin
				// Stop and reload only at the end of the low phase: no runt
				if (count >= per - PW'(1)) begin
					count <= '0;
					if (run) begin
						per     <= period_in;
						clk_out <= 1'b1;
						wrap    <= 1'b1;
					end else begin
						clk_out <= 1'b0;
						idle    <= 1'b1;
					end
				end else begin
					count   <= count + PW'(1);
					clk_out <= (count + PW'(1)) < half;
				end
			end
		end
	end

endmodule : hcoc_divider

// ---- hcoc_host_model.sv ----
// Host-side model that measures the phases of the supplied clock
`timescale 1ns/1ns
module hcoc_host_model (
	// System
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Supplied clock
	input  wire logic        host_clk,
	// Measurements in system cycles; n_rise counts rising edges
	output logic      [15:0] last_hi,
	output logic      [15:0] last_lo,
	output logic      [15:0] min_phase,
	output logic      [15:0] n_rise,
	output logic      [15:0] quiet
);
	logic        prev;
	logic [15:0] cnt;

	////////////////////////////////////////////////////////////////////////////////
	// A runt pulse shows up as a short phase in min_phase
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			prev      <= 1'b0;
			cnt       <= 16'h0001;
			last_hi   <= 16'h0000;
			last_lo   <= 16'h0000;
			min_phase <= 16'hFFFF;
			n_rise    <= 16'h0000;
			quiet     <= 16'h0000;
		end else if (host_clk !== prev) begin
			prev  <= host_clk;
			cnt   <= 16'h0001;
			quiet <= 16'h0000;
			if (prev) begin
				last_hi <= cnt;
			end else begin
				last_lo <= cnt;
				n_rise  <= n_rise + 16'h0001;
			end
			if (cnt < min_phase) begin
				min_phase <= cnt;
			end
		end else begin
			cnt <= cnt + 16'h0001;
			if (quiet != 16'hFFFF) begin
				quiet <= quiet + 16'h0001;
			end
		end
	end
endmodule : hcoc_host_model

// ---- hcoc_pkg.sv ----
// Types shared by the host clock block
package hcoc_pkg;

	typedef enum logic [2:0] {
		ST_OFF, ST_STANDBY, ST_SLEEP, ST_READY, ST_TUNING, ST_TX
	} hcoc_dev_state_t;

	typedef enum logic [1:0] {
		M_STOP, M_RUN, M_SWAP, M_TAIL
	} hcoc_mode_t;

endpackage : hcoc_pkg

// ---- hcoc_top.sv ----
// Host clock output, tail procedure and general configuration registers
//
// Contract
// - Host clock source follows the device state: RC or crystal oscillator.
// - While the crystal runs it is the source; RC is not selectable.
// - RC divides by 1 or 128; crystal by sixteen coded ratios.
// - Entering hold state, give programmed extra cycles then stop the clock.
// - Software picks 0, 64, 256 or 512 extra cycles.
// - Raise an event telling the host the hold transition is under way.
// - Ready to hold transition takes at most 98304 digital clock periods.
// - Sleep switches source crystal to RC; leaving sleep switches back.
// - Source switches are glitch-free, aligned to an RC clock edge.
// - Clock absent when off, tail in hold, RC in sleep, crystal otherwise.
// - Read-write registers fully accessible; read-only registers ignore writes.
// - Read-and-reset registers clear after the host reads them.
// - Bits 1:0 at 0x00 select battery threshold; reset 00.
// - Bits 4:2 at 0x00 set crystal driver strength; reset 011.
// - Bit 6 at 0x01 selects 26 or 24 MHz tuning; reset 1.
// - Bit 5 at 0x01 enables the encryption engine; reset 0.
// - Bit 4 at 0x01 selects external reference pin; reset 0.
// - Bits 2..0 at 0x01 enable brownout, battery detector, temperature sensor.
// - Pin registers: select in 7:3 reset 10100, mode in 1:0 reset 10.
// - Tail field 6:5 codes 0, 64, 256, 512 extra cycles.
// - Clock config bit 7 runs the divider so the host clock exists.
`timescale 1ns/1ns
`include "hcoc_cfg.svh"
module hcoc_top #(
	parameter int TAIL_MAX_CYC = `HCOC_TAIL_MAX_CYC,
	parameter int PW           = `HCOC_PER_W
)(
	// System
	input  wire logic                     clk_sys,
	input  wire logic                     rstn,
	// Register port from the serial front end
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	input  wire logic [7:0]               reg_addr,
	input  wire logic [7:0]               reg_wdata,
	output logic      [7:0]               reg_rdata,
	// Oscillators and device state
	input  wire logic                     xo_clk,
	input  wire logic                     rc_clk,
	input  wire hcoc_pkg::hcoc_dev_state_t dev_state,
	// Host clock
	output logic                          host_clk,
	output logic                          hold_event,
	// Analog controls
	output logic      [1:0]               battery_threshold_select,
	output logic      [2:0]               osc_driver_gm,
	output logic                          ref_freq_select,
	output logic                          aes_enable,
	output logic                          external_reference_select,
	output logic                          brownout_detect_enable,
	output logic                          battery_low_detector,
	output logic                          temp_sensor_enable,
	// Pin configuration
	output logic      [7:0]               pin3_config,
	output logic      [7:0]               pin2_config
);

	////////////////////////////////////////////////////////////////////////////
	logic [7:0]                analog_function_config_1;
	logic [7:0]                analog_function_config_0;
	logic [7:0]                host_clock_config;
	logic [1:0]                events_rr;
	hcoc_pkg::hcoc_mode_t      mode;
	logic                      src_xo;
	logic                      rc_prev;
	logic                      rc_edge;
	logic                      want_xo;
	logic                      want_rc;
	logic                      div_run;
	logic                      div_idle;
	logic                      div_wrap;
	logic [PW-1:0]             per_sel;
	logic [`HCOC_TAIL_W-1:0]   tail_target;
	logic [`HCOC_TAIL_W-1:0]   tail_cnt;
	logic [`HCOC_WD_W-1:0]     wd_cnt;
	logic                      wd_hit;
	logic                      tail_start;
	logic                      tail_end;
	logic [3:0]                crystal_divider_code;
	logic                      rc_divider_select;

	////////////////////////////////////////////////////////////////////////////
	// Crystal ratio as period in crystal half periods
	function automatic logic [PW-1:0] xo_period(input logic [3:0] code);
		logic [PW-1:0] p;
		p = 9'h002;
		case (code)
			4'h0:    p = 9'h002;
			4'h1:    p = 9'h003;
			4'h2:    p = 9'h004;
			4'h3:    p = 9'h006;
			4'h4:    p = 9'h008;
			4'h5:    p = 9'h00C;
			4'h6:    p = 9'h010;
			4'h7:    p = 9'h018;
			4'h8:    p = 9'h020;
			4'h9:    p = 9'h030;
			4'hA:    p = 9'h048;
			4'hB:    p = 9'h060;
			4'hC:    p = 9'h080;
			4'hD:    p = 9'h0C0;
			4'hE:    p = 9'h100;
			default: p = 9'h180;
		endcase
		return p;
	endfunction : xo_period

	assign crystal_divider_code = host_clock_config[`HCOC_XO_HI:`HCOC_XO_LO];
	assign rc_divider_select    = host_clock_config[`HCOC_RC_BIT];
	assign per_sel = src_xo ? xo_period(crystal_divider_code)
		: (rc_divider_select ? `HCOC_PER_RC128 : `HCOC_PER_RC1);

	always_comb begin
		case (host_clock_config[`HCOC_TAIL_HI:`HCOC_TAIL_LO])
			2'h0:    tail_target = `HCOC_TAIL_0;
			2'h1:    tail_target = `HCOC_TAIL_1;
			2'h2:    tail_target = `HCOC_TAIL_2;
			default: tail_target = `HCOC_TAIL_3;
		endcase
	end

	// Active states want the crystal, sleep wants RC
	assign want_xo = dev_state == hcoc_pkg::ST_READY || dev_state == hcoc_pkg::ST_TUNING
		|| dev_state == hcoc_pkg::ST_TX;
	assign want_rc = dev_state == hcoc_pkg::ST_SLEEP;
	assign rc_edge = rc_clk != rc_prev;
	assign wd_hit  = wd_cnt >= `HCOC_WD_W'(TAIL_MAX_CYC);

	// Divider runs only when enabled and in a clocked mode
	assign div_run = host_clock_config[`HCOC_CLK_EN_BIT]
		&& (mode == hcoc_pkg::M_RUN
		|| (mode == hcoc_pkg::M_TAIL && tail_cnt < tail_target && !wd_hit));

	////////////////////////////////////////////////////////////////////////////
	hcoc_divider #(
		.PW        (PW)
	) u_div (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.src_level (src_xo ? xo_clk : rc_clk),
		.period_in (per_sel),
		.run       (div_run),
		.clk_out   (host_clk),
		.idle      (div_idle),
		.wrap      (div_wrap)
	);

	////////////////////////////////////////////////////////////////////////////
	// Source mode control
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mode       <= hcoc_pkg::M_STOP;
			src_xo     <= 1'b1;
			rc_prev    <= 1'b0;
			tail_cnt   <= '0;
			wd_cnt     <= '0;
			hold_event <= 1'b0;
			tail_start <= 1'b0;
			tail_end   <= 1'b0;
		end else begin
			rc_prev    <= rc_clk;
			hold_event <= 1'b0;
			tail_start <= 1'b0;
			tail_end   <= 1'b0;
			case (mode)
				hcoc_pkg::M_STOP: begin
					if (want_xo || want_rc)
						mode <= hcoc_pkg::M_SWAP;
				end
				hcoc_pkg::M_RUN: begin
					if (dev_state == hcoc_pkg::ST_STANDBY) begin
						mode       <= hcoc_pkg::M_TAIL;
						tail_cnt   <= '0;
						wd_cnt     <= '0;
						hold_event <= 1'b1;
						tail_start <= 1'b1;
					end else if (dev_state == hcoc_pkg::ST_OFF) begin
						// Let the running period finish before stopping
						mode <= hcoc_pkg::M_SWAP;
					end else if (want_xo != src_xo) begin
						mode <= hcoc_pkg::M_SWAP;
					end
				end
				hcoc_pkg::M_SWAP: begin
					// Divider idle means the output is low; flip on an RC edge
					if (!(want_xo || want_rc)) begin
						if (div_idle)
							mode <= hcoc_pkg::M_STOP;
					end else if (div_idle && rc_edge) begin
						src_xo <= want_xo;
						mode   <= hcoc_pkg::M_RUN;
					end
				end
				default: begin
					if (!wd_hit)
						wd_cnt <= wd_cnt + `HCOC_WD_W'(1);
					if (div_wrap)
						tail_cnt <= tail_cnt + `HCOC_TAIL_W'(1);
					if (want_xo || want_rc) begin
						mode <= hcoc_pkg::M_SWAP;
					end else if (div_idle && !div_run) begin
						mode     <= hcoc_pkg::M_STOP;
						tail_end <= 1'b1;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration writes; status and event registers take no writes
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			analog_function_config_1 <= `HCOC_RST_ANA1;
			analog_function_config_0 <= `HCOC_RST_ANA0;
			pin3_config              <= `HCOC_RST_PIN;
			pin2_config              <= `HCOC_RST_PIN;
			host_clock_config        <= `HCOC_RST_CLKCFG;
		end else if (reg_wr) begin
			// Reserved bits are stored as written; the host keeps them
			if (reg_addr == `HCOC_ADDR_ANA1) begin
				analog_function_config_1 <= reg_wdata;
			end else if (reg_addr == `HCOC_ADDR_ANA0) begin
				analog_function_config_0 <= reg_wdata;
			end else if (reg_addr == `HCOC_ADDR_PIN3) begin
				pin3_config <= reg_wdata;
			end else if (reg_addr == `HCOC_ADDR_PIN2) begin
				pin2_config <= reg_wdata;
			end else if (reg_addr == `HCOC_ADDR_CLKCFG) begin
				host_clock_config <= reg_wdata;
			end
		end
	end

	// Event flags: a new event in the read cycle survives the clear
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			events_rr <= 2'h0;
		end else begin
			events_rr <= ((reg_rd && reg_addr == `HCOC_ADDR_EVENTS) ? 2'h0 : events_rr)
				| {tail_end, tail_start};
		end
	end

	// Read data, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `HCOC_ADDR_ANA1) begin
				reg_rdata <= analog_function_config_1;
			end else if (reg_addr == `HCOC_ADDR_ANA0) begin
				reg_rdata <= analog_function_config_0;
			end else if (reg_addr == `HCOC_ADDR_PIN3) begin
				reg_rdata <= pin3_config;
			end else if (reg_addr == `HCOC_ADDR_PIN2) begin
				reg_rdata <= pin2_config;
			end else if (reg_addr == `HCOC_ADDR_CLKCFG) begin
				reg_rdata <= host_clock_config;
			end else if (reg_addr == `HCOC_ADDR_STATUS) begin
				reg_rdata <= {4'h0, mode == hcoc_pkg::M_STOP, mode == hcoc_pkg::M_TAIL,
					!div_idle, src_xo};
			end else if (reg_addr == `HCOC_ADDR_EVENTS) begin
				reg_rdata <= {6'h00, events_rr};
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Analog controls straight from the register flops
	assign battery_threshold_select  = analog_function_config_1[1:0];
	assign osc_driver_gm             = analog_function_config_1[4:2];
	assign ref_freq_select           = analog_function_config_0[`HCOC_REF26_BIT];
	assign aes_enable                = analog_function_config_0[`HCOC_AES_BIT];
	assign external_reference_select = analog_function_config_0[`HCOC_EXTREF_BIT];
	assign brownout_detect_enable    = analog_function_config_0[`HCOC_BROWN_BIT];
	assign battery_low_detector      = analog_function_config_0[`HCOC_BATT_BIT];
	assign temp_sensor_enable        = analog_function_config_0[`HCOC_TEMP_BIT];

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	stopped_low_a: assert property (
		mode == hcoc_pkg::M_STOP && $past(mode == hcoc_pkg::M_STOP) |-> !host_clk)
		else $error("host clock not low while stopped");

	hold_notice_a: assert property (
		mode == hcoc_pkg::M_RUN && dev_state == hcoc_pkg::ST_STANDBY
		|=> hold_event && mode == hcoc_pkg::M_TAIL ##1 !hold_event)
		else $error("hold event not a single pulse on tail entry");

	switch_edge_a: assert property (
		$changed(src_xo) |-> $past(rc_edge) && $past(div_idle) && host_clk == 1'b0)
		else $error("source switched off an RC edge or while clock ran");

	to_rc_sleep_a: assert property (
		$fell(src_xo) |-> $past(dev_state == hcoc_pkg::ST_SLEEP))
		else $error("RC chosen outside sleep");

	xo_forced_a: assert property (
		mode == hcoc_pkg::M_RUN && want_xo && !src_xo |=> mode == hcoc_pkg::M_SWAP)
		else $error("crystal state kept RC source");

	ratio_boundary_a: assert property (
		$changed(u_div.per) |-> $past(u_div.idle) || $past(u_div.count == u_div.per - 9'h001))
		else $error("divider ratio changed mid period");

	tail_bound_a: assert property (
		mode == hcoc_pkg::M_TAIL |-> wd_cnt <= `HCOC_WD_W'(TAIL_MAX_CYC))
		else $error("tail ran past its bound");

	tail_count_a: assert property (
		mode == hcoc_pkg::M_TAIL |-> tail_cnt <= tail_target)
		else $error("tail gave more periods than programmed");

	cfg_write_a: assert property (
		reg_wr && reg_addr == `HCOC_ADDR_CLKCFG |=> host_clock_config == $past(reg_wdata))
		else $error("clock config write lost");

	rr_clear_a: assert property (
		reg_rd && reg_addr == `HCOC_ADDR_EVENTS && !tail_start && !tail_end
		|=> events_rr == 2'h0 ##1 (reg_rdata == 8'h00 || !$past(reg_rd)
		|| $past(reg_addr) != `HCOC_ADDR_EVENTS))
		else $error("event register not cleared by read");

	div_off_a: assert property (
		!host_clock_config[`HCOC_CLK_EN_BIT] && div_idle |=> !host_clk)
		else $error("host clock runs while disabled");

	tail_seen_c: cover property (mode == hcoc_pkg::M_TAIL ##[1:1000] tail_end);
	rc_switch_c: cover property ($fell(src_xo) ##[1:1000] $rose(src_xo));
	rr_read_c:   cover property (events_rr != 2'h0 && reg_rd && reg_addr == `HCOC_ADDR_EVENTS);

endmodule : hcoc_top

// ---- hcoc_top_tb.sv ----
// Self-checking testbench of the host clock block
`timescale 1ns/1ns
`include "hcoc_cfg.svh"
module hcoc_top_tb;
	localparam int XH  = 3;    // Crystal half period, slow enough to be sampled
	localparam int RH  = 5;    // RC half period
	localparam int CAP = 4000; // Short tail watchdog keeps the run brief
	localparam int XP[16] = '{2,3,4,6,8,12,16,24,32,48,72,96,128,192,256,384};
	localparam int TL[4]  = '{0,64,256,512};

	logic                      clk_sys = 1'b0;
	logic                      rstn = 1'b0;
	logic                      reg_wr = 1'b0;
	logic                      reg_rd = 1'b0;
	logic [7:0]                reg_addr = 8'h00;
	logic [7:0]                reg_wdata = 8'h00;
	logic [7:0]                reg_rdata;
	logic                      xo_clk = 1'b0;
	logic                      rc_clk = 1'b0;
	hcoc_pkg::hcoc_dev_state_t dev_state = hcoc_pkg::ST_OFF;
	logic                      host_clk, hold_event, ref_freq_select, aes_enable;
	logic                      external_reference_select, brownout_detect_enable;
	logic                      battery_low_detector, temp_sensor_enable;
	logic [1:0]                battery_threshold_select;
	logic [2:0]                osc_driver_gm;
	logic [7:0]                pin3_config, pin2_config;
	logic [15:0]               last_hi, last_lo, min_phase, n_rise, quiet;
	logic [31:0]               ana, pins;
	int                        n_fail = 0, n_checks = 0, n_hold = 0, xc = 0, rcc = 0;

	assign ana  = {21'h0, battery_threshold_select, osc_driver_gm, ref_freq_select, aes_enable,
		external_reference_select, brownout_detect_enable, battery_low_detector,
		temp_sensor_enable};
	assign pins = {16'h0, pin3_config, pin2_config};

	always #20 clk_sys = ~clk_sys;

	// Free-running oscillators, changed off the sampling edge
	always @(negedge clk_sys) begin
		xc  <= (xc == XH - 1) ? 0 : xc + 1;
		rcc <= (rcc == RH - 1) ? 0 : rcc + 1;
		if (xc == XH - 1) xo_clk <= ~xo_clk;
		if (rcc == RH - 1) rc_clk <= ~rc_clk;
		if (hold_event === 1'b1) n_hold <= n_hold + 1;
	end

	hcoc_top #(.TAIL_MAX_CYC(CAP)) hcoc_top_i (.clk_sys(clk_sys), .rstn(rstn),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .xo_clk(xo_clk), .rc_clk(rc_clk), .dev_state(dev_state),
		.host_clk(host_clk), .hold_event(hold_event),
		.battery_threshold_select(battery_threshold_select), .osc_driver_gm(osc_driver_gm),
		.ref_freq_select(ref_freq_select), .aes_enable(aes_enable),
		.external_reference_select(external_reference_select),
		.brownout_detect_enable(brownout_detect_enable),
		.battery_low_detector(battery_low_detector), .temp_sensor_enable(temp_sensor_enable),
		.pin3_config(pin3_config), .pin2_config(pin2_config));

	hcoc_host_model hcoc_host_model_i (.clk_sys(clk_sys), .rstn(rstn), .host_clk(host_clk),
		.last_hi(last_hi), .last_lo(last_lo), .min_phase(min_phase), .n_rise(n_rise),
		.quiet(quiet));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict;
		$display("checks=%0d failures=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_wr    = 1'b1;
		reg_addr  = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_rd   = 1'b1;
		reg_addr = a;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask : rd

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		check(32'(d), 32'(exp));
	endtask : rdchk

	task automatic set_state(input hcoc_pkg::hcoc_dev_state_t s);
		@(negedge clk_sys);
		dev_state = s;
	endtask : set_state

	// Bounded waits: a stuck clock counts as a mismatch instead of hanging
	task automatic wait_rises(input int n);
		logic [15:0] s;
		int          k;
		s = n_rise;
		k = 0;
		while (int'(16'(n_rise - s)) < n && k < 20000) begin
			@(negedge clk_sys);
			k++;
		end
		check(32'(k < 20000), 32'h1);
	endtask : wait_rises

	task automatic wait_quiet(input int q, input int lim, output int k);
		k = 0;
		while (int'(quiet) < q && k < lim) begin
			@(negedge clk_sys);
			k++;
		end
	endtask : wait_quiet

	// Third rise guarantees a whole period after any ratio change
	task automatic measure(input int hi, input int lo);
		wait_rises(3);
		@(negedge clk_sys);
		check(32'(last_hi), hi);
		check(32'(last_lo), lo);
	endtask : measure

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [7:0]  d;
		logic [15:0] s;
		rdchk(`HCOC_ADDR_ANA1, 8'h0C);
		rdchk(`HCOC_ADDR_ANA0, 8'hC0);
		rdchk(`HCOC_ADDR_PIN3, 8'hA2);
		rdchk(`HCOC_ADDR_PIN2, 8'hA2);
		rdchk(`HCOC_ADDR_CLKCFG, 8'h00);
		check(ana, 32'h0E0);
		check(pins, 32'hA2A2);
		s = n_rise;
		set_state(hcoc_pkg::ST_READY);
		repeat (100) @(negedge clk_sys);
		check(32'(n_rise), 32'(s));
		check(32'(host_clk), 32'h0);
		wr(`HCOC_ADDR_STATUS, 8'hFF);
		rd(`HCOC_ADDR_STATUS, d);
		check(32'(d[7:4]), 32'h0);
		wr(8'h20, 8'h55);
		rdchk(8'h20, 8'h00);
	endtask : t_reset

	// Reserved bits are written back at their reset values
	task automatic t_rw;
		wr(`HCOC_ADDR_ANA1, 8'h17);
		wr(`HCOC_ADDR_ANA0, 8'hB7);
		wr(`HCOC_ADDR_PIN3, 8'h5B);
		wr(`HCOC_ADDR_PIN2, 8'hC9);
		check(ana, 32'h75F);
		check(pins, 32'h5BC9);
		rdchk(`HCOC_ADDR_ANA1, 8'h17);
		rdchk(`HCOC_ADDR_ANA0, 8'hB7);
		rdchk(`HCOC_ADDR_PIN3, 8'h5B);
		rdchk(`HCOC_ADDR_PIN2, 8'hC9);
		wr(`HCOC_ADDR_ANA0, 8'hC0);
		check(ana, 32'h760);
	endtask : t_rw

	// RC select bit toggles too: it must not matter while the crystal runs
	task automatic t_xo;
		logic [7:0] d;
		for (int c = 0; c < 16; c++) begin
			wr(`HCOC_ADDR_CLKCFG, {1'b1, 2'b00, 4'(c), 1'(c)});
			measure(((XP[c] + 1) / 2) * XH, (XP[c] / 2) * XH);
		end
		rd(`HCOC_ADDR_STATUS, d);
		check(32'(d[0]), 32'h1);
	endtask : t_xo

	task automatic t_rc;
		logic [7:0] d;
		wr(`HCOC_ADDR_CLKCFG, 8'h80);
		set_state(hcoc_pkg::ST_SLEEP);
		measure(RH, RH);
		rd(`HCOC_ADDR_STATUS, d);
		check(32'(d[0]), 32'h0);
		wr(`HCOC_ADDR_CLKCFG, 8'h81);
		measure(128 * RH, 128 * RH);
		set_state(hcoc_pkg::ST_READY);
		measure(XH, XH);
	endtask : t_rc

	task automatic t_off;
		int k;
		int h;
		h = n_hold;
		set_state(hcoc_pkg::ST_OFF);
		wait_quiet(60, 500, k);
		check(32'(k < 500), 32'h1);
		check(32'(n_hold - h), 32'h0);
	endtask : t_off

	task automatic t_tail;
		logic [7:0]  d;
		logic [15:0] s;
		int          h;
		int          k;
		for (int i = 0; i < 4; i++) begin
			// Every active state must run the crystal clock
			set_state(i == 1 ? hcoc_pkg::ST_TUNING
				: (i == 2 ? hcoc_pkg::ST_TX : hcoc_pkg::ST_READY));
			wr(`HCOC_ADDR_CLKCFG, {1'b1, 2'(i), 5'h00});
			wait_rises(2);
			@(negedge clk_sys);
			s = n_rise;
			h = n_hold;
			dev_state = hcoc_pkg::ST_STANDBY;
			wait_quiet(40, 5000, k);
			check(32'(16'(n_rise - s)), TL[i]);
			check(32'(n_hold - h), 32'h1);
			rdchk(`HCOC_ADDR_EVENTS, 8'h03);
			rdchk(`HCOC_ADDR_EVENTS, 8'h00);
			rd(`HCOC_ADDR_STATUS, d);
			check(32'(d[3]), 32'h1);
			check(32'(host_clk), 32'h0);
		end
	endtask : t_tail

	// Longest tail on crystal code 3 (divide by 3) runs into the watchdog
	task automatic t_wd;
		logic [15:0] s;
		int          k;
		set_state(hcoc_pkg::ST_READY);
		wr(`HCOC_ADDR_CLKCFG, 8'hE6);
		wait_rises(2);
		@(negedge clk_sys);
		s = n_rise;
		dev_state = hcoc_pkg::ST_STANDBY;
		wait_quiet(60, 8000, k);
		check(32'(k < CAP + 200), 32'h1);
		check(32'(16'(n_rise - s) < 16'd512), 32'h1);
		check(32'(min_phase >= 16'(XH)), 32'h1);
	endtask : t_wd

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(40 * 80000);
		n_fail++;
		print_verdict();
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		rstn = 1'b1;
		t_reset();
		t_rw();
		t_xo();
		t_rc();
		t_off();
		t_tail();
		t_wd();
		print_verdict();
	end
endmodule : hcoc_top_tb
